// *** rtl/acac_pkg.sv ***
// shared constants and types for the ciphering register link
package acac_pkg;

    // ------------------------------------------------------------
    // link widths and word indexes (byte offset / 4)
    // ------------------------------------------------------------
    localparam int          ADDR_W      = 6;
    localparam int          DATA_W      = 32;
    localparam int          BLK_W       = 128;
    localparam int          KEY_W       = 256;
    localparam int          KEY_WORDS   = 8;
    localparam int          NONCE_WORDS = 4;
    localparam logic [5:0]  IDX_STATUS  = 6'h00;
    localparam logic [5:0]  IDX_CTRL    = 6'h01;
    localparam logic [5:0]  IDX_PWD     = 6'h04;
    localparam logic [5:0]  IDX_KEY     = 6'h08;
    localparam logic [5:0]  IDX_NONCE   = 6'h10;

    // ------------------------------------------------------------
    // password entry
    // ------------------------------------------------------------
    localparam logic [31:0] PWD_CLEAR   = 32'h0000_0100;
    localparam int          PWD_MIN     = 8;
    localparam int          PWD_MAX     = 15;
    localparam int          PWD_LEN_W   = 5;
    localparam logic [4:0]  PWD_REF_LEN = 5'h08;
    // arbitrary reference value, eight letters and digits
    localparam logic [119:0] reference_password_constant =
        120'h00_0000_0000_0000_5a71_376d_4b32_7057;

    // ------------------------------------------------------------
    // status and control bit positions
    // ------------------------------------------------------------
    localparam int          STAT_AUTH   = 0;
    localparam int          STAT_TRIED  = 1;
    localparam int          STAT_BUSY   = 2;
    localparam int          STAT_FAIL   = 29;
    localparam int          STAT_CIPHER = 30;
    localparam int          CTRL_BYPASS = 0;
    localparam int          CTRL_FAULT  = 1;

    // ------------------------------------------------------------
    // keystream core and known answer check vectors
    // ------------------------------------------------------------
    localparam logic [127:0] KS_CONST   =
        128'h6a09_e667_bb67_ae85_3c6e_f372_a54f_f53a;
    localparam logic [255:0] TEST_KEY   =
        256'h0001_0203_0405_0607_0809_0a0b_0c0d_0e0f_1011_1213_1415_1617_1819_1a1b_1c1d_1e1f;
    localparam logic [127:0] TEST_CTR   =
        128'hf0f1_f2f3_f4f5_f6f7_f8f9_fafb_fcfd_feff;
    localparam logic [127:0] TEST_PT    =
        128'h6bc1_bee2_2e40_9f96_e93d_7e11_7393_172a;

    // stand-in mixing core; a full round core drops in here
    function automatic logic [127:0] acac_keystream(
        input logic [255:0] key,
        input logic [127:0] ctr
    );
        acac_keystream = key[255:128] ^ key[127:0] ^ KS_CONST
                       ^ {ctr[63:0], ctr[127:64]};
    endfunction

    // ------------------------------------------------------------
    // host side register map (byte offsets) and command bits
    // ------------------------------------------------------------
    localparam logic [7:0]  HOFF_CMD    = 8'h00;
    localparam logic [7:0]  HOFF_WDATA  = 8'h04;
    localparam logic [7:0]  HOFF_RDATA  = 8'h08;
    localparam logic [7:0]  HOFF_STAT   = 8'h0c;
    localparam int          CMD_WR      = 0;
    localparam int          CMD_RD      = 1;
    localparam int          CMD_SRST    = 2;
    localparam int          CMD_ADDR    = 8;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ENC  = 2'b01,
        ST_DEC  = 2'b10
    } acac_st_t;

    typedef enum logic [1:0] {
        HS_IDLE    = 2'b00,
        HS_STROBE  = 2'b01,
        HS_CAPTURE = 2'b10
    } acac_hs_t;

endpackage

// *** rtl/acac_link_if.sv ***
// register read/write and soft reset link between controller and device
`timescale 1ns/1ps
`default_nettype none
interface acac_link_if;
    import acac_pkg::*;
    logic              reg_wr;
    logic              reg_rd;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic [DATA_W-1:0] reg_rdata;
    logic              soft_rst;

    modport dev (
        input  reg_wr,
        input  reg_rd,
        input  reg_addr,
        input  reg_wdata,
        input  soft_rst,
        output reg_rdata
    );

    modport ctl (
        output reg_wr,
        output reg_rd,
        output reg_addr,
        output reg_wdata,
        output soft_rst,
        input  reg_rdata
    );
endinterface
`default_nettype wire

// *** rtl/acac_device.sv ***
// counter-mode ciphering device with login, key load and self-tests
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module acac_device
    import acac_pkg::*;
#(
    parameter int BLOCK_W = BLK_W
) (
    input  wire logic               mclk_i,
    input  wire logic               sys_rst_i,
    acac_link_if.dev                link,
    input  wire logic [BLOCK_W-1:0] data_in_i,
    input  wire logic               data_in_valid_i,
    output logic      [BLOCK_W-1:0] data_out_o,
    output logic                    data_out_valid_o,
    output logic                    aes_enabled_o
);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    // the keystream core works on exactly one 128-bit block
    if (BLOCK_W != BLK_W) begin : g_bad_width
        $error("acac_device: BLOCK_W must equal 128");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [119:0]         pw_buf_q;
    logic [PWD_LEN_W-1:0] pw_len_q;
    logic                 auth_q;
    logic                 tried_q;
    logic                 bypass_q;
    logic                 fault_q;
    logic [KEY_W-1:0]     key_q;
    logic [BLK_W-1:0]     nonce_q;
    logic [BLK_W-1:0]     blk_cnt_q;
    acac_st_t             st_q;
    logic [BLK_W-1:0]     st_ct_q;
    logic                 st_bad_q;
    logic                 fail_q;
    logic [DATA_W-1:0]    rdata_q;
    logic [BLOCK_W-1:0]   dout_q;
    logic                 dvalid_q;

    logic                 srst;
    logic                 pw_wr;
    logic                 pw_clr;
    logic                 pw_add;
    logic [119:0]         pw_buf_d;
    logic [PWD_LEN_W-1:0] pw_len_d;
    logic                 ctrl_wr;
    logic                 bypass_flip;
    logic                 st_busy;
    logic                 load_ok;
    logic                 key_wr;
    logic                 nonce_wr;
    logic [5:0]           key_idx;
    logic [5:0]           nonce_idx;
    logic [BLK_W-1:0]     ctr_now;
    logic [BLK_W-1:0]     ks_test;
    logic                 pass_ok;

    assign srst        = link.soft_rst;
    assign st_busy     = (st_q != ST_IDLE);
    assign ctrl_wr     = link.reg_wr && (link.reg_addr == IDX_CTRL);
    assign bypass_flip = ctrl_wr && (link.reg_wdata[CTRL_BYPASS] != bypass_q);
    assign load_ok     = auth_q && !fail_q;
    assign key_idx     = link.reg_addr - IDX_KEY;
    assign nonce_idx   = link.reg_addr - IDX_NONCE;
    assign key_wr      = link.reg_wr && load_ok
                       && (link.reg_addr >= IDX_KEY)
                       && (key_idx < 6'(KEY_WORDS));
    assign nonce_wr    = link.reg_wr && load_ok
                       && (link.reg_addr >= IDX_NONCE)
                       && (nonce_idx < 6'(NONCE_WORDS));
    assign ks_test     = acac_keystream(TEST_KEY, TEST_CTR);

    // ------------------------------------------------------------
    // password entry
    // ------------------------------------------------------------
    assign pw_wr  = link.reg_wr && (link.reg_addr == IDX_PWD);
    assign pw_clr = pw_wr && (link.reg_wdata == PWD_CLEAR);
    assign pw_add = pw_wr && !pw_clr;

    always_comb begin
        pw_buf_d = pw_buf_q;
        pw_len_d = pw_len_q;
        if (pw_clr) begin
            pw_buf_d = '0;
            pw_len_d = '0;
        end else if (pw_add) begin
            pw_buf_d = {pw_buf_q[111:0], link.reg_wdata[7:0]};
            // saturate one past the longest length so overlong never matches
            if (pw_len_q <= PWD_LEN_W'(PWD_MAX)) begin
                pw_len_d = pw_len_q + PWD_LEN_W'(1);
            end
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pw_buf_q <= '0;
            pw_len_q <= '0;
        end else if (srst) begin
            pw_buf_q <= '0;
            pw_len_q <= '0;
        end else begin
            pw_buf_q <= pw_buf_d;
            pw_len_q <= pw_len_d;
        end
    end

    // character set is the writer's duty; any byte is simply compared
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            auth_q  <= 1'b0;
            tried_q <= 1'b0;
        end else if (srst) begin
            auth_q  <= 1'b0;
            tried_q <= 1'b0;
        end else if (pw_clr) begin
            auth_q  <= 1'b0;
        end else if (pw_add) begin
            tried_q <= 1'b1;
            auth_q  <= (pw_len_d == PWD_REF_LEN)
                    && (pw_len_d >= PWD_LEN_W'(PWD_MIN))
                    && (pw_len_d <= PWD_LEN_W'(PWD_MAX))
                    && (pw_buf_d == reference_password_constant);
        end
    end

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bypass_q <= 1'b0;
            fault_q  <= 1'b0;
        end else if (srst) begin
            bypass_q <= 1'b0;
            fault_q  <= 1'b0;
        end else if (ctrl_wr) begin
            bypass_q <= link.reg_wdata[CTRL_BYPASS];
            fault_q  <= link.reg_wdata[CTRL_FAULT];
        end
    end

    // ------------------------------------------------------------
    // key and nonce storage
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            key_q   <= '0;
            nonce_q <= '0;
        end else if (srst) begin
            key_q   <= '0;
            nonce_q <= '0;
        end else begin
            // word at the lowest index is the most significant
            if (key_wr) begin
                key_q[(KEY_WORDS-1-int'(key_idx))*DATA_W +: DATA_W]
                    <= link.reg_wdata;
            end
            if (nonce_wr) begin
                nonce_q[(NONCE_WORDS-1-int'(nonce_idx))*DATA_W +: DATA_W]
                    <= link.reg_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // self-test sequencer
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q     <= ST_ENC;
            st_ct_q  <= '0;
            st_bad_q <= 1'b0;
            fail_q   <= 1'b0;
        end else if (srst || bypass_flip) begin
            st_q     <= ST_ENC;
            st_bad_q <= 1'b0;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    st_q <= ST_IDLE;
                end
                ST_ENC: begin
                    st_ct_q  <= TEST_PT ^ ks_test;
                    st_bad_q <= ((TEST_PT ^ ks_test) == TEST_PT);
                    st_q     <= ST_DEC;
                end
                ST_DEC: begin
                    fail_q <= st_bad_q || fault_q
                           || ((st_ct_q ^ ks_test) != TEST_PT);
                    st_q   <= ST_IDLE;
                end
                default: begin
                    st_q <= ST_ENC;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // data path
    // ------------------------------------------------------------
    assign ctr_now = nonce_q + blk_cnt_q;
    assign pass_ok = !st_busy && !fail_q && (bypass_q || auth_q);

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            blk_cnt_q <= '0;
        end else if (srst || nonce_wr) begin
            blk_cnt_q <= '0;
        end else if (data_in_valid_i && pass_ok && !bypass_q) begin
            blk_cnt_q <= blk_cnt_q + BLK_W'(1);
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dout_q   <= '0;
            dvalid_q <= 1'b0;
        end else begin
            dvalid_q <= data_in_valid_i && pass_ok;
            if (!(data_in_valid_i && pass_ok)) begin
                dout_q <= '0;
            end else if (bypass_q) begin
                dout_q <= data_in_i;
            end else begin
                dout_q <= data_in_i ^ acac_keystream(key_q, ctr_now);
            end
        end
    end

    assign data_out_o       = dout_q;
    assign data_out_valid_o = dvalid_q;
    assign aes_enabled_o    = !bypass_q && !fail_q && !st_busy;

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    // key and nonce are never readable
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_q <= '0;
        end else if (link.reg_rd) begin
            rdata_q <= '0;
            if (link.reg_addr == IDX_STATUS) begin
                rdata_q[STAT_AUTH]   <= auth_q;
                rdata_q[STAT_TRIED]  <= tried_q;
                rdata_q[STAT_BUSY]   <= st_busy;
                rdata_q[STAT_FAIL]   <= fail_q;
                rdata_q[STAT_CIPHER] <= !bypass_q;
            end else if (link.reg_addr == IDX_CTRL) begin
                rdata_q[CTRL_BYPASS] <= bypass_q;
                rdata_q[CTRL_FAULT]  <= fault_q;
            end
        end
    end

    assign link.reg_rdata = rdata_q;

endmodule
`default_nettype wire

// *** rtl/acac_host.sv ***
// controller end: ahb-lite slave that drives the device register link
`timescale 1ns/1ps
`default_nettype none
module acac_host
    import acac_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic      [31:0] hrdata_o,
    acac_link_if.ctl         link
);

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    logic              wr_pend_q;
    logic [7:0]        wr_addr_q;
    logic [31:0]       hrdata_q;
    logic [DATA_W-1:0] wdata_q;
    logic [DATA_W-1:0] rdata_q;
    acac_hs_t          hs_q;
    logic              op_wr_q;
    logic              op_rd_q;
    logic              srst_q;
    logic [ADDR_W-1:0] addr_q;
    logic              addr_ph;
    logic              cmd_wr;

    // only whole-word singles are issued, so hsize is not decoded
    assign addr_ph = hsel_i && htrans_i[1] && hready_i;
    assign cmd_wr  = wr_pend_q && (wr_addr_q == HOFF_CMD);

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
            hrdata_q  <= '0;
        end else if (addr_ph) begin
            wr_pend_q <= hwrite_i;
            wr_addr_q <= haddr_i[7:0];
            hrdata_q  <= '0;
            if (!hwrite_i) begin
                unique case (haddr_i[7:0])
                    HOFF_WDATA: hrdata_q <= wdata_q;
                    HOFF_RDATA: hrdata_q <= rdata_q;
                    HOFF_STAT:  hrdata_q <= {31'h0000_0000, hs_q != HS_IDLE};
                    default:    hrdata_q <= '0;
                endcase
            end
        end else if (hready_i) begin
            wr_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wdata_q <= '0;
        end else if (wr_pend_q && (wr_addr_q == HOFF_WDATA)) begin
            wdata_q <= hwdata_i;
        end
    end

    // zero wait states, always okay
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign hrdata_o    = hrdata_q;

    // ------------------------------------------------------------
    // link sequencer
    // ------------------------------------------------------------
    // commands arriving while busy are dropped; poll status first
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hs_q    <= HS_IDLE;
            op_wr_q <= 1'b0;
            op_rd_q <= 1'b0;
            srst_q  <= 1'b0;
            addr_q  <= '0;
            rdata_q <= '0;
        end else begin
            unique case (hs_q)
                HS_IDLE: begin
                    if (cmd_wr) begin
                        op_wr_q <= hwdata_i[CMD_WR];
                        op_rd_q <= hwdata_i[CMD_RD] && !hwdata_i[CMD_WR];
                        srst_q  <= hwdata_i[CMD_SRST];
                        addr_q  <= hwdata_i[CMD_ADDR +: ADDR_W];
                        if (|hwdata_i[CMD_SRST:CMD_WR]) begin
                            hs_q <= HS_STROBE;
                        end
                    end
                end
                HS_STROBE: begin
                    op_wr_q <= 1'b0;
                    op_rd_q <= 1'b0;
                    srst_q  <= 1'b0;
                    hs_q    <= HS_CAPTURE;
                end
                HS_CAPTURE: begin
                    // status taken as read, caller judges validity
                    rdata_q <= link.reg_rdata;
                    hs_q    <= HS_IDLE;
                end
                default: begin
                    hs_q <= HS_IDLE;
                end
            endcase
        end
    end

    // strobes stand only in the strobe state
    assign link.reg_wr     = op_wr_q && (hs_q == HS_STROBE);
    assign link.reg_rd     = op_rd_q && (hs_q == HS_STROBE);
    assign link.soft_rst   = srst_q && (hs_q == HS_STROBE);
    assign link.reg_addr   = addr_q;
    assign link.reg_wdata  = wdata_q;

endmodule
`default_nettype wire

// *** bench/acac_assertions.sv ***
// link protocol checker between controller and ciphering device
`timescale 1ns/1ps
`default_nettype none
module acac_assertions
    import acac_pkg::*;
(
    input  wire logic              mclk_i,
    input  wire logic              sys_rst_i,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic [DATA_W-1:0] reg_rdata,
    input  wire logic              soft_rst
);
    // ------------------------------------------------------------
    // helper state: bypass bit and cleared password buffer
    // ------------------------------------------------------------
    logic byp_q;
    logic clr_q;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            byp_q <= 1'b0;
        else if (soft_rst)
            byp_q <= 1'b0;
        else if (reg_wr && reg_addr == IDX_CTRL)
            byp_q <= reg_wdata[CTRL_BYPASS];
    end

    // a clear also holds after any reset, no append seen since
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            clr_q <= 1'b1;
        else if (soft_rst)
            clr_q <= 1'b1;
        else if (reg_wr && reg_addr == IDX_PWD)
            clr_q <= (reg_wdata == PWD_CLEAR);
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_wr_strobe_pulse: assert property (reg_wr |=> !reg_wr)
        else $error("write strobe longer than one cycle");
    a_rd_strobe_pulse: assert property (reg_rd |=> !reg_rd)
        else $error("read strobe longer than one cycle");
    a_srst_one_pulse: assert property (soft_rst |=> !soft_rst)
        else $error("soft reset longer than one cycle");
    a_single_link_op: assert property (!(reg_wr && reg_rd))
        else $error("read and write strobes together");
    a_key_never_read: assert property
        (reg_rd && reg_addr >= IDX_KEY |=> reg_rdata == '0)
        else $error("key or nonce word readable");
    a_pwd_never_read: assert property
        (reg_rd && reg_addr == IDX_PWD |=> reg_rdata == '0)
        else $error("password buffer readable");
    a_clear_drops_auth: assert property
        (reg_rd && reg_addr == IDX_STATUS && clr_q
         |=> !reg_rdata[STAT_AUTH])
        else $error("login kept after clear");
    a_bypass_bit_thirty: assert property
        (reg_rd && reg_addr == IDX_STATUS
         |=> reg_rdata[STAT_CIPHER] == !byp_q)
        else $error("bit 30 disagrees with bypass");

    c_soft_reset: cover property (soft_rst);
    c_bypass_write: cover property (reg_wr && reg_addr == IDX_CTRL);
    c_status_read: cover property (reg_rd && reg_addr == IDX_STATUS);
endmodule
`default_nettype wire

// *** bench/tb.sv ***
// testbench: ahb controller facing the ciphering device
`timescale 1ns/1ps
`default_nettype none
module tb;
    import acac_pkg::*;
    logic         mclk_i    = 1'b0;
    logic         sys_rst_i = 1'b1;
    logic [31:0]  haddr     = '0;
    logic [1:0]   htrans    = '0;
    logic         hwrite    = 1'b0;
    logic [31:0]  hwdata    = '0;
    logic [31:0]  hrdata;
    logic         hready;
    logic         hresp;
    logic [127:0] din       = '0;
    logic         dv        = 1'b0;
    logic [127:0] dout;
    logic         dov;
    logic         aen;
    logic [31:0]  rd;
    logic [127:0] res;
    logic         got;
    int           mismatches  = 0;
    int           comparisons = 0;

    acac_link_if link ();
    always #4 mclk_i = ~mclk_i;

    acac_host i_acac_host (.mclk_i, .sys_rst_i, .hsel_i(1'b1),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hready),
        .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
        .link(link));
    acac_device i_acac_device (.mclk_i, .sys_rst_i, .link(link),
        .data_in_i(din), .data_in_valid_i(dv), .data_out_o(dout),
        .data_out_valid_o(dov), .aes_enabled_o(aen));
    acac_assertions i_acac_assertions (.mclk_i, .sys_rst_i,
        .reg_wr(link.reg_wr), .reg_rd(link.reg_rd),
        .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
        .reg_rdata(link.reg_rdata), .soft_rst(link.soft_rst));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string w, input logic [127:0] e,
                       input logic [127:0] s);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", w, e, s);
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk_i);
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {24'h0000_00, a};
        do @(posedge mclk_i); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge mclk_i); while (hready !== 1'b1);
        q = hrdata;
    endtask

    // polls busy; a stuck controller is caught by the watchdog
    task automatic dcmd(input logic [5:0] idx, input logic [2:0] op);
        ahb(1'b1, HOFF_CMD, {18'h0_0000, idx, 5'h00, op}, rd);
        do ahb(1'b0, HOFF_STAT, 32'h0000_0000, rd);
        while (rd[0] !== 1'b0);
    endtask

    task automatic dwr(input logic [5:0] idx, input logic [31:0] d);
        ahb(1'b1, HOFF_WDATA, d, rd);
        dcmd(idx, 3'b001);
    endtask

    task automatic drd(input logic [5:0] idx, output logic [31:0] q);
        dcmd(idx, 3'b010);
        ahb(1'b0, HOFF_RDATA, 32'h0000_0000, q);
    endtask

    task automatic login(input logic [63:0] pw);
        dwr(IDX_PWD, PWD_CLEAR);
        for (int i = 7; i >= 0; i--)
            dwr(IDX_PWD, {24'h0000_00, pw[i*8 +: 8]});
    endtask

    task automatic blk(input logic [127:0] b);
        @(posedge mclk_i);
        din <= b;
        dv  <= 1'b1;
        @(posedge mclk_i);
        dv  <= 1'b0;
        got = 1'b0;
        res = '0;
        repeat (2) begin
            @(posedge mclk_i);
            if (dov === 1'b1 && !got) begin
                got = 1'b1;
                res = dout;
            end
        end
    endtask

    function automatic logic [127:0] ks(input logic [255:0] k,
                                        input logic [127:0] c);
        return k[255:128] ^ k[127:0] ^ KS_CONST ^ {c[63:0], c[127:64]};
    endfunction

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        #100_000;
        mismatches++;
        conclude();
    end

    initial begin
        repeat (3) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        chk("enabled", 1, aen);
        blk(TEST_PT);
        chk("valid", 0, got);
        dwr(IDX_KEY, 32'hdead_beef);
        login(64'h5a71_376d_4b32_7058);
        drd(IDX_STATUS, rd);
        chk("status", 32'h4000_0002, rd);
        chk("hresp", 0, hresp);
        login(reference_password_constant[63:0]);
        drd(IDX_STATUS, rd);
        chk("status", 32'h4000_0003, rd);
        blk(TEST_PT);
        chk("out", TEST_PT ^ ks('0, '0), res);
        for (int i = 0; i < KEY_WORDS; i++)
            dwr(6'(IDX_KEY + i), TEST_KEY[255 - 32*i -: 32]);
        for (int i = 0; i < NONCE_WORDS; i++)
            dwr(6'(IDX_NONCE + i), TEST_CTR[127 - 32*i -: 32]);
        drd(IDX_KEY, rd);
        chk("key", 0, rd);
        drd(IDX_PWD, rd);
        chk("pwd", 0, rd);
        blk(TEST_PT);
        chk("out", TEST_PT ^ ks(TEST_KEY, TEST_CTR), res);
        blk(TEST_PT);
        chk("out", TEST_PT ^ ks(TEST_KEY, TEST_CTR + 1), res);
        dwr(IDX_CTRL, 32'h0000_0001);
        drd(IDX_STATUS, rd);
        chk("status", 32'h0000_0003, rd);
        chk("enabled", 0, aen);
        blk(TEST_CTR);
        chk("out", TEST_CTR, res);
        // leaving bypass with an injected fault must fail the check
        dwr(IDX_CTRL, 32'h0000_0002);
        drd(IDX_CTRL, rd);
        chk("ctrl", 32'h0000_0002, rd);
        drd(IDX_STATUS, rd);
        chk("status", 32'h6000_0003, rd);
        chk("enabled", 0, aen);
        blk(TEST_PT);
        chk("valid", 0, got);
        dcmd(IDX_STATUS, 3'b100);
        login(reference_password_constant[63:0]);
        drd(IDX_STATUS, rd);
        chk("status", 32'h4000_0003, rd);
        blk(TEST_PT);
        chk("out", TEST_PT ^ ks('0, '0), res);
        // a bare clear must drop the login at once
        dwr(IDX_PWD, PWD_CLEAR);
        drd(IDX_STATUS, rd);
        chk("status", 32'h4000_0002, rd);
        conclude();
    end
endmodule
`default_nettype wire
